/* File: verilog/signal_bank_output_mux.sv */
// Debug pin bank multiplexer with timing and state capture modes
//
// Behaviour
// RULE_01: Pin count is a build parameter, any value from 1 to 256.
// RULE_02: Each pin muxes over all banks and drives its own index of the chosen bank.
// RULE_03: Bank count is a build parameter, any value from 1 to 256.
// RULE_04: Timing mode passes signals unregistered; the analyzer samples with its own clock.
// RULE_05: State mode registers the selected signals on a sample clock from the design.
// RULE_06: Sample clock select exists only in state mode; any design signal may serve.
// RULE_07: Integrator should choose a sample clock fast enough for the signals of interest.
// RULE_08: After reset pins are either all tri-stated or drive one chosen bank. In state mode driven pins show zeros until the first sample edge.
// RULE_09: Bank selection and output enable are controllable at run time over the access port.
// RULE_10: Bank index is binary; in state mode a change shows at the next sample edge.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

module signal_bank_output_mux #(
    parameter int PIN_COUNT = 8,
    parameter int BANK_COUNT = 1,
    parameter int STATE_MODE = 1,
    parameter int SRC_COUNT = 4,
    parameter int POWERUP_TRISTATE = 1,
    parameter int POWERUP_BANK = 0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sbo_pkg::ADDR_W-1:0] paddr,
    input wire logic [sbo_pkg::DATA_W-1:0] pwdata,
    output logic [sbo_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [BANK_COUNT*PIN_COUNT-1:0] probeBus,
    input wire logic [SRC_COUNT-1:0] sampleSrc,
    output logic [PIN_COUNT-1:0] laPinOut,
    output logic [PIN_COUNT-1:0] laPinOe
);

    // Index widths follow the configured counts
    localparam int BANK_W = (BANK_COUNT > 1) ? $clog2(BANK_COUNT) : 1; // RULE_03 RULE_10
    localparam int SRC_W = (SRC_COUNT > 1) ? $clog2(SRC_COUNT) : 1;
    localparam int PIN_CLAMP = (PIN_COUNT > sbo_pkg::MAX_PINS) ? sbo_pkg::MAX_PINS : PIN_COUNT; // RULE_01
    localparam int BANK_CLAMP = (BANK_COUNT > sbo_pkg::MAX_BANKS) ? sbo_pkg::MAX_BANKS : BANK_COUNT;
    localparam int RD_PINS = (PIN_COUNT > sbo_pkg::DATA_W) ? sbo_pkg::DATA_W : PIN_COUNT;
    localparam logic IS_STATE = (STATE_MODE != 0);

    // Power-up choice: tri-state, or drive a valid bank
    localparam logic OE_RST = (POWERUP_TRISTATE == 0); // RULE_08
    localparam int BANK_RST_INT = (POWERUP_BANK < BANK_COUNT) ? POWERUP_BANK : 0;
    localparam logic [BANK_W-1:0] BANK_RST = BANK_W'(BANK_RST_INT); // RULE_08
    localparam logic [SRC_W-1:0] CLKSEL_RST = '0;
    localparam logic [PIN_COUNT-1:0] CAPTURE_RST = '0;

    // Control state
    logic outEn_q;
    logic hold_q;
    logic [BANK_W-1:0] bankSel_q;
    logic [BANK_W-1:0] activeBank_q;
    logic [SRC_W-1:0] clkSel_q;
    logic [31:0] sampleCnt_q;
    logic [PIN_COUNT-1:0] capture_q;
    logic [PIN_COUNT-1:0] delay_q [sbo_pkg::DATA_DELAY];
    logic [sbo_pkg::DATA_W-1:0] prdata_q;

    // Bus decode
    logic setupPh;
    logic accessPh;
    logic wrEn;
    logic [sbo_pkg::ADDR_W-1:0] regAddr;
    logic hitCtrl;
    logic hitBank;
    logic hitClkSel;
    logic mapped;
    logic bankBad;
    logic [sbo_pkg::DATA_W-1:0] rdata_d;

    // Datapath
    logic [PIN_COUNT-1:0] muxData;
    logic selectedSrc;
    logic sampleRise;
    logic takeSample;
    logic countClear;

    assign setupPh = psel && !penable;
    assign accessPh = psel && penable;
    assign wrEn = accessPh && pwrite;
    assign regAddr = {paddr[sbo_pkg::ADDR_W-1:2], 2'b00};

    assign hitCtrl = (regAddr == sbo_pkg::OFF_CTRL);
    assign hitBank = (regAddr == sbo_pkg::OFF_BANK);
    assign hitClkSel = (regAddr == sbo_pkg::OFF_CLKSEL);
    assign mapped = hitCtrl || hitBank || hitClkSel
        || (regAddr == sbo_pkg::OFF_STATUS)
        || (regAddr == sbo_pkg::OFF_SAMPLES)
        || (regAddr == sbo_pkg::OFF_PINS)
        || (regAddr == sbo_pkg::OFF_CONFIG);

    // Bank index beyond the configured count is refused
    assign bankBad = hitBank && (pwdata >= sbo_pkg::DATA_W'(BANK_COUNT)); // RULE_10

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = accessPh && (!mapped || (pwrite && bankBad));

    // Output enable, run-time controllable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            outEn_q <= OE_RST; // RULE_08
        end else if (wrEn && hitCtrl) begin
            outEn_q <= pwdata[sbo_pkg::CTRL_OE_BIT]; // RULE_09
        end
    end

    // Capture hold, freezes the pins in state mode
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold_q <= sbo_pkg::RST_HOLD;
        end else if (wrEn && hitCtrl) begin
            hold_q <= pwdata[sbo_pkg::CTRL_HOLD_BIT];
        end
    end

    // Requested bank, binary index
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bankSel_q <= BANK_RST; // RULE_08
        end else if (wrEn && hitBank && !bankBad) begin
            bankSel_q <= pwdata[BANK_W-1:0]; // RULE_09 RULE_10
        end
    end

    // Sample clock source select; absent in timing mode
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clkSel_q <= CLKSEL_RST;
        end else if (IS_STATE && wrEn && hitClkSel) begin
            clkSel_q <= pwdata[SRC_W-1:0]; // RULE_06
        end
    end

    bank_signal_mux #(
        .PIN_COUNT(PIN_COUNT),
        .BANK_COUNT(BANK_COUNT),
        .BANK_W(BANK_W)
    ) u_mux (
        .probeBus(probeBus),
        .bankSel(bankSel_q),
        .pinData(muxData)
    );

    // Any design signal may be the sample clock; out of range picks none
    assign selectedSrc = IS_STATE && (int'(clkSel_q) < SRC_COUNT) && sampleSrc[clkSel_q]; // RULE_06

    // Sample clock is oversampled by mclk, so it must stay well below
    // a quarter of mclk for every edge to be seen
    sample_edge_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .asyncIn(selectedSrc),
        .level(),
        .rise(sampleRise)
    );

    assign takeSample = IS_STATE && sampleRise && !hold_q;

    // Data delayed to match synchroniser latency, so the captured
    // word is the one present at the sample clock edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < sbo_pkg::DATA_DELAY; i++) begin
                delay_q[i] <= CAPTURE_RST;
            end
        end else begin
            delay_q[0] <= muxData;
            for (int i = 1; i < sbo_pkg::DATA_DELAY; i++) begin
                delay_q[i] <= delay_q[i-1];
            end
        end
    end

    // State mode capture on each sample edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            capture_q <= CAPTURE_RST;
        end else if (takeSample) begin
            capture_q <= delay_q[sbo_pkg::DATA_DELAY-1]; // RULE_05
        end
    end

    // Bank whose data is on the pins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            activeBank_q <= BANK_RST;
        end else if (!IS_STATE || takeSample) begin
            activeBank_q <= bankSel_q; // RULE_10
        end
    end

    // Sample edge counter; a clear with a new edge in the same cycle restarts it at 1
    assign countClear = wrEn && hitCtrl && pwdata[sbo_pkg::CTRL_CLR_BIT];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sampleCnt_q <= sbo_pkg::RST_SAMPLES;
        end else if (takeSample && countClear) begin
            sampleCnt_q <= 32'h0000_0001;
        end else if (countClear) begin
            sampleCnt_q <= sbo_pkg::RST_SAMPLES;
        end else if (takeSample) begin
            sampleCnt_q <= sampleCnt_q + 32'h0000_0001;
        end
    end

    // Timing mode is a pure combinational path to the pins; the
    // analyzer's own clock does the sampling
    assign laPinOut = IS_STATE ? capture_q : muxData; // RULE_04 RULE_05
    assign laPinOe = {PIN_COUNT{outEn_q}}; // RULE_08

    // Read data
    always_comb begin
        rdata_d = '0;
        case (regAddr)
            sbo_pkg::OFF_CTRL: begin
                rdata_d[sbo_pkg::CTRL_OE_BIT] = outEn_q;
                rdata_d[sbo_pkg::CTRL_HOLD_BIT] = hold_q;
            end
            sbo_pkg::OFF_BANK: begin
                rdata_d[BANK_W-1:0] = bankSel_q;
            end
            sbo_pkg::OFF_CLKSEL: begin
                if (IS_STATE) begin
                    rdata_d[SRC_W-1:0] = clkSel_q;
                end
            end
            sbo_pkg::OFF_STATUS: begin
                rdata_d[sbo_pkg::STAT_MODE_BIT] = IS_STATE;
                rdata_d[sbo_pkg::STAT_OE_BIT] = outEn_q;
                rdata_d[sbo_pkg::STAT_PEND_BIT] = (activeBank_q != bankSel_q);
                rdata_d[sbo_pkg::STAT_HOLD_BIT] = hold_q;
                rdata_d[sbo_pkg::STAT_BANK_LSB +: BANK_W] = activeBank_q;
            end
            sbo_pkg::OFF_SAMPLES: begin
                rdata_d = sampleCnt_q;
            end
            sbo_pkg::OFF_PINS: begin
                rdata_d[RD_PINS-1:0] = laPinOut[RD_PINS-1:0];
            end
            sbo_pkg::OFF_CONFIG: begin
                rdata_d[sbo_pkg::CFG_PINS_LSB +: sbo_pkg::CFG_CNT_W] = sbo_pkg::CFG_CNT_W'(PIN_CLAMP);
                rdata_d[sbo_pkg::CFG_BANKS_LSB +: sbo_pkg::CFG_CNT_W] = sbo_pkg::CFG_CNT_W'(BANK_CLAMP);
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    // Read data registered in the setup cycle, held through access
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata_q <= '0;
        end else if (setupPh) begin
            prdata_q <= pwrite ? '0 : rdata_d;
        end
    end

    assign prdata = prdata_q;

endmodule : signal_bank_output_mux

`default_nettype wire

/* File: inc/sbo_pkg.sv */
// Shared constants for the debug signal bank output multiplexer
package sbo_pkg;

    // Register bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_BANK = 12'h004;
    localparam logic [11:0] OFF_CLKSEL = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_SAMPLES = 12'h010;
    localparam logic [11:0] OFF_PINS = 12'h014;
    localparam logic [11:0] OFF_CONFIG = 12'h018;

    // CTRL fields
    localparam int CTRL_OE_BIT = 0;
    localparam int CTRL_HOLD_BIT = 1;
    localparam int CTRL_CLR_BIT = 2;

    // STATUS fields
    localparam int STAT_MODE_BIT = 0;
    localparam int STAT_OE_BIT = 1;
    localparam int STAT_PEND_BIT = 2;
    localparam int STAT_HOLD_BIT = 3;
    localparam int STAT_BANK_LSB = 8;

    // CONFIG fields
    localparam int CFG_PINS_LSB = 0;
    localparam int CFG_BANKS_LSB = 16;
    localparam int CFG_CNT_W = 9;

    // Build-time limits
    localparam int MAX_PINS = 256;
    localparam int MAX_BANKS = 256;

    // Values after reset
    localparam logic RST_HOLD = 1'b0;
    localparam logic [31:0] RST_SAMPLES = 32'h0000_0000;

    // Sample clock synchroniser and matching data delay
    localparam int SYNC_STAGES = 3;
    localparam int DATA_DELAY = 3;

endpackage : sbo_pkg

/* File: verilog/sample_edge_sync.sv */
// Three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps
`default_nettype none

module sample_edge_sync (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic asyncIn,
    output logic level,
    output logic rise
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // First stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= asyncIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign level = level_q;
    assign rise = (s2_q == s3_q) && s3_q && !level_q;

endmodule : sample_edge_sync

`default_nettype wire

/* File: verilog/bank_signal_mux.sv */
// Per-pin multiplexer over the signal banks
`timescale 1ns/10ps
`default_nettype none

module bank_signal_mux #(
    parameter int PIN_COUNT = 8,
    parameter int BANK_COUNT = 1,
    parameter int BANK_W = 1
) (
    input wire logic [BANK_COUNT*PIN_COUNT-1:0] probeBus,
    input wire logic [BANK_W-1:0] bankSel,
    output logic [PIN_COUNT-1:0] pinData
);

    // Bank b, pin p sits at probeBus[b*PIN_COUNT + p]
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
        logic [BANK_COUNT-1:0] column;
        for (genvar b = 0; b < BANK_COUNT; b++) begin : g_bank
            assign column[b] = probeBus[b*PIN_COUNT+p];
        end
        // Out-of-range index drives low rather than an unknown
        assign pinData[p] = (int'(bankSel) < BANK_COUNT) ? column[bankSel] : 1'b0; // RULE_02
    end

endmodule : bank_signal_mux

`default_nettype wire

/* File: verif/sbo_checker.sv */
// Port-level assertions for the debug bank output multiplexer
`timescale 1ns/10ps
`default_nettype none

module sbo_checker #(
    parameter int PIN_COUNT = 8,
    parameter int BANK_COUNT = 1,
    parameter int SRC_COUNT = 4,
    parameter int STATE_MODE = 1,
    parameter int POWERUP_TRISTATE = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sbo_pkg::ADDR_W-1:0] paddr,
    input wire logic [sbo_pkg::DATA_W-1:0] pwdata,
    input wire logic [sbo_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [SRC_COUNT-1:0] sampleSrc,
    input wire logic [PIN_COUNT-1:0] laPinOut,
    input wire logic [PIN_COUNT-1:0] laPinOe
);
    logic [SRC_COUNT-1:0] srcPrev_q;
    logic [3:0] sinceRise_q;
    wire logic acc = psel && penable;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge mclk) begin
        srcPrev_q <= sampleSrc;
    end

    // Cycles since any source rose; pins may only move shortly after one
    always_ff @(posedge mclk) begin
        if (!rst_n || |(sampleSrc & ~srcPrev_q)) begin
            sinceRise_q <= 4'h0;
        end else if (sinceRise_q != 4'hf) begin
            sinceRise_q <= sinceRise_q + 4'h1;
        end
    end

    a_ready_high: assert property (pready) else $error("pready low");
    a_oe_uniform: assert property (laPinOe == '0 || laPinOe == '1) else $error("enables differ");
    a_oe_powerup: assert property ($rose(rst_n) |-> laPinOe == {PIN_COUNT{POWERUP_TRISTATE == 0}})
        else $error("power-up enable wrong");
    a_oe_write: assert property (acc && pwrite && paddr[11:2] == sbo_pkg::OFF_CTRL[11:2]
        |=> laPinOe == {PIN_COUNT{$past(pwdata[0])}}) else $error("enable not applied");
    a_bank_range: assert property (acc && pwrite && paddr[11:2] == sbo_pkg::OFF_BANK[11:2]
        && pwdata >= BANK_COUNT |-> pslverr) else $error("bank out of range accepted");
    a_unmapped_err: assert property (acc && paddr[11:2] > 10'h006 |-> pslverr)
        else $error("unmapped access without error");
    a_err_access: assert property (pslverr |-> acc) else $error("error outside access");
    a_cfg_read: assert property (acc && !pwrite && paddr[11:2] == sbo_pkg::OFF_CONFIG[11:2]
        |-> prdata[8:0] == 9'(PIN_COUNT) && prdata[24:16] == 9'(BANK_COUNT)) else $error("config wrong");
    a_pins_cause: assert property (STATE_MODE != 0 && !$stable(laPinOut) |-> sinceRise_q <= 4'h8)
        else $error("pins moved without sample edge");
endmodule : sbo_checker

bind signal_bank_output_mux sbo_checker #(.PIN_COUNT(PIN_COUNT), .BANK_COUNT(BANK_COUNT),
    .SRC_COUNT(SRC_COUNT), .STATE_MODE(STATE_MODE), .POWERUP_TRISTATE(POWERUP_TRISTATE)) chkI (.mclk(mclk),
    .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sampleSrc(sampleSrc), .laPinOut(laPinOut), .laPinOe(laPinOe));

`default_nettype wire

/* File: verif/la_probe_model.sv */
// External analyzer model sampling the debug header on its own clock
`timescale 1ns/10ps
`default_nettype none

module la_probe_model #(
    parameter int PIN_COUNT = 8
) (
    input wire logic [PIN_COUNT-1:0] pins,
    input wire logic [PIN_COUNT-1:0] oe,
    output logic [PIN_COUNT-1:0] seen
);
    logic aClk = 1'b0;
    logic [PIN_COUNT-1:0] seen_q = '0;

    always #7.3 aClk = ~aClk;

    // Undriven pins float: show them toggling, never a stale value
    always @(posedge aClk) begin
        seen_q <= (oe & pins) | (~oe & ~seen_q);
    end

    assign seen = seen_q;
endmodule : la_probe_model

`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the debug bank output multiplexer
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int PINS = 8;
    localparam int BANKS = 4;
    logic mclk = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, er, preadyT, pslverrT, erT;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, bus, prdataT, rdT;
    logic [3:0] sampleSrc;
    logic [7:0] laPinOut, laPinOe, seen, expPins, pinsT, oeT;
    int errorCnt = 0;
    int numChecks = 0;

    signal_bank_output_mux #(.PIN_COUNT(PINS), .BANK_COUNT(BANKS)) uut (.mclk(mclk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .probeBus(bus), .sampleSrc(sampleSrc), .laPinOut(laPinOut),
        .laPinOe(laPinOe));
    la_probe_model #(.PIN_COUNT(PINS)) analyzer (.pins(laPinOut), .oe(laPinOe), .seen(seen));
    // Second build: timing mode, powering up onto bank 1 with pins driven
    signal_bank_output_mux #(.PIN_COUNT(PINS), .BANK_COUNT(BANKS), .STATE_MODE(0), .POWERUP_TRISTATE(0),
        .POWERUP_BANK(1)) uutTiming (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdataT), .pready(preadyT),
        .pslverr(pslverrT), .probeBus(bus), .sampleSrc(sampleSrc), .laPinOut(pinsT), .laPinOe(oeT));

    always #10 mclk = ~mclk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Setup, then access held until pready; one idle cycle after
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 || preadyT !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        rdT = prdataT;
        er = pslverr;
        erT = pslverrT;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic pulse(input int s);
        sampleSrc[s] <= 1'b1;
        repeat (5) @(posedge mclk);
        sampleSrc[s] <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask : pulse

    function automatic logic [7:0] pick(input int b, input logic [31:0] v);
        return v[b*PINS +: PINS];
    endfunction : pick

    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sampleSrc = 4'h0;
        void'($urandom(32'h6cfa));
        bus = $urandom;
        fork
            begin
                repeat (10) @(posedge mclk);
                rst_n <= 1'b1;
                @(posedge mclk);
                chk("oe after reset", 32'h0, {24'h0, laPinOe});
                chk("pins after reset", 32'h0, {24'h0, laPinOut});
                chk("timing oe after reset", 32'hff, {24'h0, oeT});
                chk("timing pins after reset", {24'h0, pick(1, bus)}, {24'h0, pinsT});
                apb(1'b0, sbo_pkg::OFF_CONFIG, 32'h0);
                chk("config", {7'h0, 9'(BANKS), 7'h0, 9'(PINS)}, rd);
                apb(1'b0, 12'h0fc, 32'h0);
                chk("unmapped error", 32'h1, {31'h0, er});
                apb(1'b1, sbo_pkg::OFF_BANK, 32'(BANKS));
                chk("bank range error", 32'h1, {31'h0, er});
                chk("timing bank range error", 32'h1, {31'h0, erT});
                apb(1'b1, sbo_pkg::OFF_CTRL, 32'h1);
                chk("oe on", 32'hff, {24'h0, laPinOe});
                for (int s = 0; s < 4; s++) begin
                    apb(1'b1, sbo_pkg::OFF_CLKSEL, 32'(s));
                    for (int k = 0; k < BANKS; k++) begin
                        apb(1'b1, sbo_pkg::OFF_BANK, 32'((s + k) % BANKS));
                        bus <= $urandom;
                        @(posedge mclk);
                        expPins = pick((s + k) % BANKS, bus);
                        chk("timing pins", {24'h0, expPins}, {24'h0, pinsT});
                        pulse(s);
                        chk("pins", {24'h0, expPins}, {24'h0, laPinOut});
                        chk("analyzer", {24'h0, expPins}, {24'h0, seen});
                        bus <= ~bus;
                        pulse((s + 1) % 4);
                        chk("other source ignored", {24'h0, expPins}, {24'h0, laPinOut});
                        chk("timing follows", {24'h0, pick((s + k) % BANKS, bus)}, {24'h0, pinsT});
                    end
                end
                apb(1'b0, sbo_pkg::OFF_STATUS, 32'h0);
                chk("status bank", 32'h2, {30'h0, rd[9:8]});
                chk("status", 32'h0000_0203, rd);
                chk("timing status", 32'h0000_0202, rdT);
                apb(1'b0, sbo_pkg::OFF_CLKSEL, 32'h0);
                chk("clock select", 32'h3, rd);
                chk("timing clock select", 32'h0, rdT);
                apb(1'b0, sbo_pkg::OFF_SAMPLES, 32'h0);
                chk("sample count", 32'h10, rd);
                apb(1'b0, sbo_pkg::OFF_PINS, 32'h0);
                chk("pins register", {24'h0, expPins}, rd);
                apb(1'b1, sbo_pkg::OFF_BANK, 32'h1);
                chk("timing bank now", {24'h0, pick(1, bus)}, {24'h0, pinsT});
                apb(1'b0, sbo_pkg::OFF_STATUS, 32'h0);
                chk("status pending", 32'h0000_0207, rd);
                apb(1'b1, sbo_pkg::OFF_CTRL, 32'h3);
                bus <= $urandom;
                pulse(3);
                chk("hold keeps pins", {24'h0, expPins}, {24'h0, laPinOut});
                apb(1'b0, sbo_pkg::OFF_SAMPLES, 32'h0);
                chk("count held", 32'h10, rd);
                apb(1'b1, sbo_pkg::OFF_CTRL, 32'h5);
                apb(1'b0, sbo_pkg::OFF_SAMPLES, 32'h0);
                chk("count cleared", 32'h0, rd);
                expPins = pick(1, bus);
                pulse(3);
                chk("pins after hold", {24'h0, expPins}, {24'h0, laPinOut});
                apb(1'b0, sbo_pkg::OFF_SAMPLES, 32'h0);
                chk("count after clear", 32'h1, rd);
            end
            begin
                repeat (8000) @(posedge mclk);
                errorCnt++;
                $display("CHECK FAILED timeout expected finish seen hang");
            end
        join_any
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
